/* File: ata_admin_cmd.sv */
// device-side handler for the power query, erase, diagnostic, flush and identify commands
//
// Contract
// - both power-query codes are accepted and report the power state without data.
// - a power query in or around standby sets busy, loads count with zero, clears busy, interrupts.
// - a power query while idle sets busy, loads count with all ones, clears busy, interrupts.
// - the pre-erase command is accepted and moves no data.
// - a failing pre-erase reports write fault and nothing else; the code also sets the error bit in status.
// - the erase start is cylinder, sector and head, or block bits 27:0 when block mode is set.
// - the count register gives how many consecutive sectors are erased.
// - the diagnostic ignores the drive bit and the master reports for both devices.
// - at diagnostic end the result code goes into the error register.
// - flush ends with ready and seek-complete set only after the cache is on the media.
// - without flush support the flush command ends with command aborted.
// - identify returns one parameter block using the single-sector data-in protocol.
// - reserved bits and words of the parameter block read as zero.
// - a finished data-in sends a status frame with its interrupt bit set, then goes idle.
`timescale 1ns/1ps
module ata_admin_cmd
  import ata_cmd_pkg::*;
#(
  parameter logic FLUSH_SUPPORTED = 1'b1,
  parameter logic DEVICE_NUM      = 1'b0
)
(
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  // task-file register port
  input  wire logic [2:0]  TF_ADDR_I,
  input  wire logic        TF_WR_I,
  input  wire logic [7:0]  TF_WDATA_I,
  input  wire logic        TF_RD_I,
  output logic      [7:0]  TF_RDATA_O,
  output logic             INTRQ_O,
  // power state and self test
  input  wire logic [1:0]  PWR_STATE_I,
  output logic             DIAG_START_O,
  input  wire logic        DIAG_DONE_I,
  input  wire logic [7:0]  DIAG_CODE_I,
  input  wire logic        SLAVE_FAIL_I,
  // media
  output logic             MEDIA_REQ_O,
  output logic             MEDIA_OP_O,
  output logic             MEDIA_CHS_O,
  output logic      [27:0] MEDIA_ADDR_O,
  input  wire logic        MEDIA_ACK_I,
  input  wire logic        MEDIA_FAULT_I,
  // data-in stream
  output logic      [15:0] DATA_O,
  output logic             DATA_VALID_O,
  input  wire logic        DATA_READY_I,
  // status frame
  output logic             FRAME_O,
  output logic      [7:0]  FRAME_STATUS_O,
  output logic      [7:0]  FRAME_ERROR_O,
  output logic             FRAME_IRQ_O
);
  typedef enum {S_IDLE, S_PWR, S_DIAG, S_MEDIA, S_ID_FETCH, S_ID_LOAD, S_ID_SEND, S_DONE} state_e;

  state_e      state_r;
  logic [7:0]  feat_r, count_r, sector_r, trk_lo_r, track_upper_r, unit_r, err_r;
  logic        busy_flag_r, drq_r, df_r, err_bit_r, seek_complete_flag_r;
  logic [7:0]  word_r;
  logic [15:0] mem_rdata;
  media_if     mq ();

  // status byte; ready stays up, this block has no not-ready phase
  wire [7:0] status = {busy_flag_r, 1'b1, df_r, seek_complete_flag_r, drq_r, 2'b00, err_bit_r};

  // register port decode; writes are refused while a command runs
  wire   tf_wr_ok = TF_WR_I && !busy_flag_r && (state_r == S_IDLE);
  wire   cmd_go   = tf_wr_ok && (TF_ADDR_I == TF_STAT_CMD);
  cmd_e  cmd_kind;
  assign cmd_kind = decode_cmd(TF_WDATA_I);
  wire   dev_hit  = (unit_r[UNIT_DEV_BIT] == DEVICE_NUM) || (cmd_kind == CK_DIAG);
  wire   cmd_take = cmd_go && dev_hit;
  wire   stat_rd  = TF_RD_I && (TF_ADDR_I == TF_STAT_CMD);
  wire   lba_mode = unit_r[UNIT_LBA_BIT];

  // start address: head or block bits 27:24 on top, then track and sector bytes
  wire [27:0] erase_start = {unit_r[3:0], track_upper_r, trk_lo_r, sector_r};
  // a count of zero asks for the full 256-sector span
  wire [8:0]  erase_span  = {(count_r == 8'h00), count_r};
  wire        pwr_sleepy  = (PWR_STATE_I != PWR_IDLE);
  wire        id_beat     = DATA_VALID_O && DATA_READY_I;
  wire        id_last     = (word_r == IDENT_LAST);
  wire        mem_rd      = (state_r == S_ID_FETCH);

  // read mux for the register port
  logic [7:0] rd_mux;
  always_comb
  begin
    case (TF_ADDR_I)
      TF_ERR_FEAT: rd_mux = err_r;
      TF_COUNT:    rd_mux = count_r;
      TF_SECTOR:   rd_mux = sector_r;
      TF_TRK_LO:   rd_mux = trk_lo_r;
      TF_TRK_HI:   rd_mux = track_upper_r;
      TF_UNIT:     rd_mux = unit_r;
      TF_STAT_CMD: rd_mux = status;
      default:     rd_mux = 8'h00;
    endcase
  end

  ident_mem u_mem (
    .clk_i   (REF_CLK_I),
    .rst_n_i (NRST_I),
    .rd_i    (mem_rd),
    .addr_i  (word_r),
    .rdata_o (mem_rdata)
  );

  media_seq u_seq (
    .clk_i   (REF_CLK_I),
    .rst_n_i (NRST_I),
    .m       (mq.seq),
    .req_o   (MEDIA_REQ_O),
    .op_o    (MEDIA_OP_O),
    .chs_o   (MEDIA_CHS_O),
    .addr_o  (MEDIA_ADDR_O),
    .ack_i   (MEDIA_ACK_I),
    .fault_i (MEDIA_FAULT_I)
  );

  // register file and command sequencing
  always_ff @(posedge REF_CLK_I)
  begin
    if (!NRST_I)
    begin
      state_r <= S_IDLE;
      {feat_r, count_r, sector_r, trk_lo_r, track_upper_r, unit_r} <= {6{TF_RESET}};
      err_r   <= ERR_RESET;
      {busy_flag_r, drq_r, df_r, err_bit_r} <= 4'h0;
      seek_complete_flag_r <= 1'b1;
      word_r <= 8'h00;
      TF_RDATA_O <= 8'h00;
      INTRQ_O <= 1'b0;
      DIAG_START_O <= 1'b0;
      DATA_O <= 16'h0000;
      DATA_VALID_O <= 1'b0;
      {FRAME_O, FRAME_IRQ_O} <= 2'b00;
      FRAME_STATUS_O <= 8'h00;
      FRAME_ERROR_O <= 8'h00;
      mq.start <= 1'b0;
      mq.op <= MOP_ERASE;
      mq.chs <= 1'b0;
      mq.addr <= '0;
      mq.count <= '0;
    end
    else
    begin
      FRAME_O <= 1'b0;
      DIAG_START_O <= 1'b0;
      mq.start <= 1'b0;
      if (TF_RD_I)
        TF_RDATA_O <= rd_mux;
      // status read acknowledges the interrupt; a completion below still wins
      if (stat_rd)
        INTRQ_O <= 1'b0;
      if (tf_wr_ok)
      begin
        case (TF_ADDR_I)
          TF_ERR_FEAT: feat_r <= TF_WDATA_I;
          TF_COUNT:    count_r <= TF_WDATA_I;
          TF_SECTOR:   sector_r <= TF_WDATA_I;
          TF_TRK_LO:   trk_lo_r <= TF_WDATA_I;
          TF_TRK_HI:   track_upper_r <= TF_WDATA_I;
          TF_UNIT:     unit_r <= TF_WDATA_I;
          default:     ;
        endcase
      end
      case (state_r)
        S_IDLE:
          if (cmd_take)
          begin
            busy_flag_r <= 1'b1;
            {df_r, err_bit_r} <= 2'b00;
            err_r <= 8'h00;
            INTRQ_O <= 1'b0;
            case (cmd_kind)
              CK_PWR:   state_r <= S_PWR;
              CK_ERASE:
              begin
                mq.start <= 1'b1;
                mq.op    <= MOP_ERASE;
                mq.chs   <= !lba_mode;
                mq.addr  <= erase_start;
                mq.count <= erase_span;
                state_r  <= S_MEDIA;
              end
              CK_DIAG:
              begin
                DIAG_START_O <= 1'b1;
                state_r <= S_DIAG;
              end
              CK_FLUSH:
                if (FLUSH_SUPPORTED)
                begin
                  seek_complete_flag_r <= 1'b0;
                  mq.start <= 1'b1;
                  mq.op    <= MOP_FLUSH;
                  mq.count <= CNT_ONE;
                  state_r  <= S_MEDIA;
                end
                else
                begin
                  err_r[ERR_ABRT] <= 1'b1;
                  err_bit_r <= 1'b1;
                  state_r <= S_DONE;
                end
              CK_IDENT:
              begin
                word_r  <= 8'h00;
                state_r <= S_ID_FETCH;
              end
              default:
              begin
                err_r[ERR_ABRT] <= 1'b1;
                err_bit_r <= 1'b1;
                state_r <= S_DONE;
              end
            endcase
          end
        S_PWR:
        begin
          count_r <= pwr_sleepy ? PWR_COUNT_STANDBY : PWR_COUNT_IDLE;
          state_r <= S_DONE;
        end
        S_DIAG:
          if (DIAG_DONE_I)
          begin
            err_r <= DIAG_CODE_I;
            err_r[DIAG_SLAVE_BIT] <= SLAVE_FAIL_I;
            state_r <= S_DONE;
          end
        S_MEDIA:
          if (mq.done)
          begin
            df_r <= mq.fault;
            err_bit_r <= mq.fault;
            seek_complete_flag_r <= 1'b1;
            state_r <= S_DONE;
          end
        S_ID_FETCH:
        begin
          busy_flag_r <= 1'b0;
          drq_r <= 1'b1;
          state_r <= S_ID_LOAD;
        end
        S_ID_LOAD:
        begin
          DATA_O <= mem_rdata;
          DATA_VALID_O <= 1'b1;
          state_r <= S_ID_SEND;
        end
        S_ID_SEND:
          if (id_beat)
          begin
            DATA_VALID_O <= 1'b0;
            word_r <= word_r + 8'h01;
            state_r <= id_last ? S_DONE : S_ID_FETCH;
          end
        S_DONE:
        begin
          // one status frame closes every command, its interrupt bit always set
          busy_flag_r <= 1'b0;
          drq_r <= 1'b0;
          INTRQ_O <= 1'b1;
          FRAME_O <= 1'b1;
          FRAME_IRQ_O <= 1'b1;
          FRAME_STATUS_O <= {1'b0, status[6:4], 1'b0, status[2:0]};
          FRAME_ERROR_O <= err_r;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence seq_query_idle;
    (state_r == S_PWR) && !pwr_sleepy;
  endsequence
  sequence seq_query_sleepy;
    (state_r == S_PWR) && pwr_sleepy;
  endsequence

  a_cmd_sets_busy: assert property (
    cmd_take |=> busy_flag_r && (state_r != S_IDLE))
    else $error("accepted command did not set busy");
  a_query_idle_ff: assert property (
    seq_query_idle |=> count_r == PWR_COUNT_IDLE ##1 (!busy_flag_r && INTRQ_O && FRAME_O))
    else $error("idle power query answer wrong");
  a_query_standby_zero: assert property (
    seq_query_sleepy |=> count_r == PWR_COUNT_STANDBY ##1 (!busy_flag_r && INTRQ_O))
    else $error("standby power query answer wrong");
  a_erase_job_args: assert property (
    (cmd_take && cmd_kind == CK_ERASE) |=> mq.start && mq.addr == $past(erase_start)
      && mq.chs == !$past(lba_mode))
    else $error("erase start address wrong");
  a_erase_span_count: assert property (
    (mq.start && mq.op == MOP_ERASE) |-> mq.count == erase_span && mq.count != 9'h000)
    else $error("erase span wrong");
  a_diag_result_code: assert property (
    (state_r == S_DIAG && DIAG_DONE_I) |=> err_r[6:0] == $past(DIAG_CODE_I[6:0])
      ##1 FRAME_O && FRAME_ERROR_O[6:0] == $past(DIAG_CODE_I[6:0], 2))
    else $error("diagnostic code not reported");
  a_flush_ready_dsc: assert property (
    (state_r == S_MEDIA && mq.done && mq.op == MOP_FLUSH && !mq.fault)
      |=> ##1 FRAME_O && FRAME_STATUS_O[ST_RDY] && FRAME_STATUS_O[ST_DSC])
    else $error("flush status lacks ready or seek complete");
  a_flush_unsupported: assert property (
    (cmd_take && cmd_kind == CK_FLUSH && !FLUSH_SUPPORTED)
      |=> err_r[ERR_ABRT] && !mq.start)
    else $error("unsupported flush not aborted");
  a_ident_end_frame: assert property (
    (state_r == S_ID_SEND && id_beat && id_last)
      |=> !DATA_VALID_O ##1 (FRAME_O && FRAME_IRQ_O && state_r == S_IDLE))
    else $error("no status frame after parameter block");
endmodule

/* File: ata_cmd_pkg.sv */
// constants, command decode and types shared by the admin command handler
package ata_cmd_pkg;
  // task-file register addresses on the register port
  localparam logic [2:0] TF_DATA     = 3'h0;
  localparam logic [2:0] TF_ERR_FEAT = 3'h1;
  localparam logic [2:0] TF_COUNT    = 3'h2;
  localparam logic [2:0] TF_SECTOR   = 3'h3;
  localparam logic [2:0] TF_TRK_LO   = 3'h4;
  localparam logic [2:0] TF_TRK_HI   = 3'h5;
  localparam logic [2:0] TF_UNIT     = 3'h6;
  localparam logic [2:0] TF_STAT_CMD = 3'h7;
  // command codes
  localparam logic [7:0] OPC_PWR_A = 8'h98;
  localparam logic [7:0] OPC_PWR_B = 8'he5;
  localparam logic [7:0] OPC_ERASE = 8'hc0;
  localparam logic [7:0] OPC_DIAG  = 8'h90;
  localparam logic [7:0] OPC_FLUSH = 8'he7;
  localparam logic [7:0] OPC_IDENT = 8'hec;
  // status, error and unit-select field positions
  localparam int ST_BUSY = 7;
  localparam int ST_RDY  = 6;
  localparam int ST_DF   = 5;
  localparam int ST_DSC  = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  localparam int ERR_ABRT = 2;
  localparam int UNIT_DEV_BIT = 4;
  localparam int UNIT_LBA_BIT = 6;
  localparam int DIAG_SLAVE_BIT = 7;
  // reset values
  localparam logic [7:0] TF_RESET  = 8'h00;
  localparam logic [7:0] ERR_RESET = 8'h01;
  // power-mode answers and power states
  localparam logic [7:0] PWR_COUNT_STANDBY = 8'h00;
  localparam logic [7:0] PWR_COUNT_IDLE    = 8'hff;
  localparam logic [1:0] PWR_IDLE    = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_ENTER   = 2'h2;
  localparam logic [1:0] PWR_EXIT    = 2'h3;
  // diagnostic result codes
  localparam logic [7:0] DIAG_OK     = 8'h01;
  localparam logic [7:0] DIAG_FMT    = 8'h02;
  localparam logic [7:0] DIAG_BUF    = 8'h03;
  localparam logic [7:0] DIAG_ECC    = 8'h04;
  localparam logic [7:0] DIAG_CPU    = 8'h05;
  // parameter block geometry and non-zero words
  localparam int IDENT_AW = 8;
  localparam logic [7:0]  IDENT_LAST = 8'hff;
  localparam logic [7:0]  ID_IDX_CFG = 8'h00;
  localparam logic [7:0]  ID_IDX_MUL = 8'h2f;
  localparam logic [7:0]  ID_IDX_VAL = 8'h35;
  localparam logic [15:0] ID_CFG     = 16'h044a;
  localparam logic [15:0] ID_MUL     = 16'h8001;
  localparam logic [15:0] ID_VAL     = 16'h0007;
  // media operations and erase span width
  localparam logic MOP_ERASE = 1'b0;
  localparam logic MOP_FLUSH = 1'b1;
  localparam int CNT_W = 9;
  localparam logic [8:0] CNT_ONE = 9'h001;

  typedef enum {CK_PWR, CK_ERASE, CK_DIAG, CK_FLUSH, CK_IDENT, CK_BAD} cmd_e;

  // command decode, shared by the dispatcher and its checks
  function automatic cmd_e decode_cmd(input logic [7:0] c);
    case (c)
      OPC_PWR_A, OPC_PWR_B: decode_cmd = CK_PWR;
      OPC_ERASE:            decode_cmd = CK_ERASE;
      OPC_DIAG:             decode_cmd = CK_DIAG;
      OPC_FLUSH:            decode_cmd = CK_FLUSH;
      OPC_IDENT:            decode_cmd = CK_IDENT;
      default:              decode_cmd = CK_BAD;
    endcase
  endfunction
endpackage

/* File: media_if.sv */
// job hand-off between the command dispatcher and the media sequencer
`timescale 1ns/1ps
interface media_if;
  logic        start;
  logic        op;
  logic        chs;
  logic [27:0] addr;
  logic [8:0]  count;
  logic        done;
  logic        fault;
  modport ctl (output start, op, chs, addr, count, input done, fault);
  modport seq (input start, op, chs, addr, count, output done, fault);
endinterface

/* File: ident_mem.sv */
// parameter block store with registered read data
`timescale 1ns/1ps
module ident_mem
  import ata_cmd_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // read port
  input  wire logic                rd_i,
  input  wire logic [IDENT_AW-1:0] addr_i,
  output logic      [15:0]         rdata_o
);
  // only a few words carry values; everything reserved reads zero
  function automatic logic [15:0] word_of(input logic [7:0] a);
    case (a)
      ID_IDX_CFG: word_of = ID_CFG;
      ID_IDX_MUL: word_of = ID_MUL;
      ID_IDX_VAL: word_of = ID_VAL;
      default:    word_of = 16'h0000;
    endcase
  endfunction

  // read register; holds its word between reads
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
      rdata_o <= word_of(addr_i);
  end

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_i && addr_i == 8'h45) |=> rdata_o == 16'h0000)
    else $error("reserved parameter word read non-zero");
endmodule

/* File: media_seq.sv */
// walks an erase span or a flush against the media, one acknowledge per sector
`timescale 1ns/1ps
module media_seq
  import ata_cmd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // job from the dispatcher
  media_if.seq             m,
  // media side
  output logic             req_o,
  output logic             op_o,
  output logic             chs_o,
  output logic [27:0]      addr_o,
  input  wire logic        ack_i,
  input  wire logic        fault_i
);
  typedef enum {Q_IDLE, Q_RUN} seq_e;
  seq_e             q_r;
  logic [CNT_W-1:0] left_r;
  wire              last_sector = (left_r == CNT_ONE);

  // request stays high across the span; each ack retires one sector
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q_r     <= Q_IDLE;
      left_r  <= '0;
      req_o   <= 1'b0;
      op_o    <= MOP_ERASE;
      chs_o   <= 1'b0;
      addr_o  <= '0;
      m.done  <= 1'b0;
      m.fault <= 1'b0;
    end
    else
    begin
      m.done <= 1'b0;
      case (q_r)
        Q_IDLE:
          if (m.start)
          begin
            op_o   <= m.op;
            chs_o  <= m.chs;
            addr_o <= m.addr;
            left_r <= m.count;
            req_o  <= 1'b1;
            q_r    <= Q_RUN;
          end
        Q_RUN:
          if (ack_i)
          begin
            // a failing sector ends the span early
            if (fault_i || last_sector)
            begin
              req_o   <= 1'b0;
              m.done  <= 1'b1;
              m.fault <= fault_i;
              q_r     <= Q_IDLE;
            end
            else
            begin
              addr_o <= addr_o + 28'h1;
              left_r <= left_r - CNT_ONE;
            end
          end
        default: q_r <= Q_IDLE;
      endcase
    end
  end
endmodule

/* File: media_model.sv */
// far-side responder: per-sector media acknowledges and self-test completion
`timescale 1ns/1ps
module media_model
(
  // clock
  input  wire logic       clk_i,
  // media side
  input  wire logic       req_i,
  input  wire logic [8:0] fault_at_i,
  output logic            ack_o,
  output logic            fault_o,
  // self test
  input  wire logic       diag_start_i,
  output logic            diag_done_o
);
  int unsigned idx;

  // one acknowledge per sector after a random settle time; fault toggles outside ack
  initial
  begin
    ack_o = 1'b0;
    fault_o = 1'b0;
    idx = 0;
    forever
    begin
      @(negedge clk_i);
      if (req_i !== 1'b1)
      begin
        // noise on the fault line while idle; only the ack edge may sample it
        idx = 0;
        fault_o = ~fault_o;
      end
      else
      begin
        repeat ($urandom_range(3)) @(negedge clk_i);
        ack_o = 1'b1;
        fault_o = (idx == fault_at_i);
        idx++;
        @(negedge clk_i);
        ack_o = 1'b0;
        fault_o = ~fault_o;
        // the request drops one edge after the last ack, so wait before looking again
        @(negedge clk_i);
      end
    end
  end

  // self test ends after a random delay
  initial
  begin
    diag_done_o = 1'b0;
    forever
    begin
      @(negedge clk_i);
      if (diag_start_i === 1'b1)
      begin
        repeat ($urandom_range(5)) @(negedge clk_i);
        diag_done_o = 1'b1;
        @(negedge clk_i);
        diag_done_o = 1'b0;
      end
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking bench for the admin command handler
`timescale 1ns/1ps
module tb_top;
  import ata_cmd_pkg::*;
  logic        clk, nrst, tf_wr_s, tf_rd_s, intrq, dstart, ddone, sfail;
  logic        mreq, mop, mchs, mack, mfault, dvalid, dready, frame, fr_irq;
  logic [2:0]  tf_addr;
  logic [7:0]  tf_wdata, tf_rdata, dcode, fr_stat, fr_err, v;
  logic [1:0]  pwr;
  logic [27:0] maddr, exp_addr, sa;
  logic [15:0] dout;
  logic [8:0]  fault_at;
  logic        erase_on, exp_chs, id_on;
  int          fails, comparisons, acks, beat, starts;

  ata_admin_cmd ata_admin_cmd_inst (.REF_CLK_I(clk), .NRST_I(nrst), .TF_ADDR_I(tf_addr),
    .TF_WR_I(tf_wr_s), .TF_WDATA_I(tf_wdata), .TF_RD_I(tf_rd_s), .TF_RDATA_O(tf_rdata),
    .INTRQ_O(intrq), .PWR_STATE_I(pwr), .DIAG_START_O(dstart), .DIAG_DONE_I(ddone),
    .DIAG_CODE_I(dcode), .SLAVE_FAIL_I(sfail), .MEDIA_REQ_O(mreq), .MEDIA_OP_O(mop),
    .MEDIA_CHS_O(mchs), .MEDIA_ADDR_O(maddr), .MEDIA_ACK_I(mack),
    .MEDIA_FAULT_I(mfault), .DATA_O(dout), .DATA_VALID_O(dvalid),
    .DATA_READY_I(dready), .FRAME_O(frame), .FRAME_STATUS_O(fr_stat),
    .FRAME_ERROR_O(fr_err), .FRAME_IRQ_O(fr_irq));

  media_model media_model_inst (.clk_i(clk), .req_i(mreq), .fault_at_i(fault_at),
    .ack_o(mack), .fault_o(mfault), .diag_start_i(dstart), .diag_done_o(ddone));

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tf_wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    tf_addr = a;
    tf_wdata = d;
    tf_wr_s = 1'b1;
    @(negedge clk);
    tf_wr_s = 1'b0;
    tf_wdata = ~d;
  endtask

  // read data is registered, so it is settled at the falling edge after the strobe
  task automatic tf_rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    tf_addr = a;
    tf_rd_s = 1'b1;
    @(negedge clk);
    tf_rd_s = 1'b0;
    d = tf_rdata;
  endtask

  // bounded wait for the status frame pulse
  task automatic wait_frame();
    int n;
    n = 0;
    while (frame !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask

  function automatic logic [15:0] id_word(input int i);
    case (i)
      0:       id_word = 16'h044a;
      47:      id_word = 16'h8001;
      53:      id_word = 16'h0007;
      default: id_word = 16'h0000;
    endcase
  endfunction

  task automatic erase(input logic [7:0] cnt, input logic lba, input logic [8:0] fat);
    int n;
    sa = 28'($urandom);
    n = (cnt == 8'h00) ? 256 : int'(cnt);
    if (fat != 9'h1ff)
      n = int'(fat) + 1;
    tf_wr(TF_SECTOR, sa[7:0]);
    tf_wr(TF_TRK_LO, sa[15:8]);
    tf_wr(TF_TRK_HI, sa[23:16]);
    tf_wr(TF_UNIT, {1'b0, lba, 2'b00, sa[27:24]});
    tf_wr(TF_COUNT, cnt);
    fault_at = fat;
    exp_addr = sa;
    exp_chs = ~lba;
    acks = 0;
    erase_on = 1'b1;
    tf_wr(TF_STAT_CMD, OPC_ERASE);
    wait_frame();
    erase_on = 1'b0;
    check(acks, n);
    tf_rd(TF_STAT_CMD, v);
    check(v & 8'he9, (fat != 9'h1ff) ? 8'h61 : 8'h40);
  endtask

  // each acknowledged sector must be the next one of the span
  always @(posedge clk)
    if (mreq === 1'b1 && mack === 1'b1)
    begin
      acks++;
      check(mop, erase_on ? MOP_ERASE : MOP_FLUSH);
      if (erase_on)
      begin
        check({mchs, maddr}, {exp_chs, exp_addr});
        exp_addr++;
      end
    end

  // every accepted identify beat against the expected parameter word
  always @(posedge clk)
    if (dvalid === 1'b1 && dready === 1'b1)
    begin
      check(dout, id_word(beat));
      beat++;
    end

  // self-test start pulses, one per diagnostic command
  always @(posedge clk)
    if (dstart === 1'b1)
      starts++;

  // host stalls the data-in stream at random
  always @(negedge clk)
    dready <= id_on ? 1'($urandom_range(1)) : 1'b0;

  // hang guard, well beyond the expected run length
  initial
  begin
    #(50 * 60000);
    fails++;
    end_sim();
  end

  initial
  begin
    nrst = 1'b0;
    tf_addr = TF_DATA;
    tf_wr_s = 1'b0;
    tf_rd_s = 1'b0;
    tf_wdata = 8'h00;
    pwr = PWR_IDLE;
    dcode = 8'h00;
    sfail = 1'b0;
    fault_at = 9'h1ff;
    erase_on = 1'b0;
    id_on = 1'b0;
    fails = 0;
    comparisons = 0;
    beat = 0;
    void'($urandom(1451));
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    tf_rd(TF_STAT_CMD, v);
    check(v, 8'h50);
    tf_rd(TF_ERR_FEAT, v);
    check(v, ERR_RESET);
    // power query: every state with both codes, unused fields filled at random
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 2; k++)
      begin
        pwr = 2'(s);
        tf_wr(TF_COUNT, 8'($urandom));
        tf_wr(TF_ERR_FEAT, 8'($urandom));
        tf_wr(TF_UNIT, {3'($urandom), 1'b0, 4'($urandom)});
        tf_wr(TF_STAT_CMD, k ? OPC_PWR_B : OPC_PWR_A);
        wait_frame();
        @(negedge clk);
        check(intrq, 1'b1);
        tf_rd(TF_COUNT, v);
        check(v, (s == 0) ? 8'hff : 8'h00);
        tf_rd(TF_STAT_CMD, v);
        check({intrq, v[ST_BUSY]}, 2'b00);
      end
    // erase: full 256 span, short CHS span, fault in mid-span
    erase(8'h00, 1'b1, 9'h1ff);
    erase(8'(1 + $urandom_range(5)), 1'b0, 9'h1ff);
    erase(8'h04, 1'b1, 9'h001);
    // diagnostic with the drive bit set, every result code
    for (int c = 1; c <= 5; c++)
    begin
      dcode = 8'(c);
      sfail = 1'($urandom_range(1));
      tf_wr(TF_UNIT, 8'h10);
      tf_wr(TF_STAT_CMD, OPC_DIAG);
      wait_frame();
      check(fr_err, {sfail, dcode[6:0]});
      tf_rd(TF_ERR_FEAT, v);
      check(v, {sfail, dcode[6:0]});
    end
    check(starts, 5);
    // other device selected: a power query must leave count alone
    pwr = PWR_IDLE;
    tf_wr(TF_COUNT, 8'h5a);
    tf_wr(TF_STAT_CMD, OPC_PWR_A);
    repeat (6) @(negedge clk);
    tf_rd(TF_COUNT, v);
    check(v, 8'h5a);
    // an unknown code ends at once with the abort bit and the error flag
    tf_wr(TF_UNIT, 8'h00);
    tf_wr(TF_STAT_CMD, 8'h22);
    wait_frame();
    check({fr_err, fr_stat & 8'h01}, 16'h0401);
    // flush: one media step, then ready and seek complete
    acks = 0;
    tf_wr(TF_UNIT, 8'h00);
    tf_wr(TF_STAT_CMD, OPC_FLUSH);
    wait_frame();
    check({acks[7:0], fr_stat & 8'hd1}, {8'h01, 8'h50});
    // identify: whole block under random stalls
    beat = 0;
    id_on = 1'b1;
    tf_wr(TF_STAT_CMD, OPC_IDENT);
    wait_frame();
    id_on = 1'b0;
    check({beat[23:0], 7'h00, fr_irq}, {24'd256, 8'h01});
    repeat (4) @(negedge clk);
    end_sim();
  end
endmodule
